// ===== src/bors_sequencer.sv
module bors_sequencer
  import bors_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // analog side
  input  wire logic       supplyLow,
  input  wire logic       pllLock,
  // configuration fields
  input  wire logic [2:0] oscSelectCfg,
  input  wire logic [1:0] primaryOscModeCfg,
  input  wire logic       powerupTimerEn,
  input  wire logic       sleepMode,
  input  wire logic       idleMode,
  // status flag software access
  input  wire logic       flagWrite,
  input  wire logic       flagWriteData,
  // outputs
  output logic            deviceResetPulse,
  output logic            internalReset,
  output logic            sysClockEn,
  output logic [2:0]      clockSource,
  output logic            oscStartupRun,
  output logic            supplyDropFlag
);
  import bors_pkg::*;

  bors_if startIf ();
  bors_if pwrIf ();

  bors_timer u_start (
    .clk (clk),
    .rst (rst),
    .tif (startIf.tmr)
  );
  bors_timer u_pwr (
    .clk (clk),
    .rst (rst),
    .tif (pwrIf.tmr)
  );

  function automatic logic uses_osc(input logic [2:0] sel);
    return (sel == OSC_PRI) || (sel == OSC_PRI_PLL);
  endfunction
  function automatic logic uses_pll(input logic [2:0] sel);
    return (sel == OSC_FRC_PLL) || (sel == OSC_PRI_PLL);
  endfunction

  bors_state_t      state;
  bors_state_t      next_state;
  logic [2:0]       pulseCnt;
  logic [2:0]       next_pulseCnt;
  logic             needStart;
  logic             needPll;
  logic             next_needStart;
  logic             next_needPll;
  logic             next_deviceResetPulse;
  logic             next_internalReset;
  logic             next_sysClockEn;
  logic [2:0]       next_clockSource;
  logic             next_oscStartupRun;
  logic             next_supplyDropFlag;
  logic             clockReady;
  logic             isCrystal;

  assign isCrystal  = (primaryOscModeCfg == POSC_XT) || (primaryOscModeCfg == POSC_HS);
  assign clockReady = (!needStart || startIf.expired) && (!needPll || pllLock);

  always_comb begin
    next_state             = state;
    next_pulseCnt          = pulseCnt;
    next_needStart         = needStart;
    next_needPll           = needPll;
    next_deviceResetPulse  = 1'b0;
    next_internalReset     = internalReset;
    next_sysClockEn        = sysClockEn;
    next_clockSource       = clockSource;
    next_oscStartupRun     = 1'b0;
    next_supplyDropFlag    = supplyDropFlag;
    startIf.load           = 1'b0;
    startIf.count          = CNT_W'(STARTUP_TMR_CYCLES);
    pwrIf.load             = 1'b0;
    pwrIf.count            = '0;
    // software clear; a drop in the same cycle wins below
    if (flagWrite && !flagWriteData) begin
      next_supplyDropFlag = 1'b0;
    end
    // detection ignores sleep and idle
    if (supplyLow) begin
      next_state            = BORS_PULSE;
      next_pulseCnt         = '0;
      next_deviceResetPulse = 1'b1;
      next_internalReset    = 1'b1;
      next_sysClockEn       = 1'b0;
      next_supplyDropFlag   = 1'b1;
    end else begin
      case (state)
        BORS_RUN: begin
          next_state = BORS_RUN;
        end
        BORS_PULSE: begin
          next_deviceResetPulse = 1'b1;
          next_pulseCnt         = pulseCnt + 3'h1;
          if (pulseCnt == 3'(RESET_PULSE_CYCLES - 1)) begin
            next_deviceResetPulse = 1'b0;
            next_clockSource      = oscSelectCfg;
            next_needStart        = uses_osc(oscSelectCfg)
                                    && (primaryOscModeCfg != POSC_EC);
            next_needPll          = uses_pll(oscSelectCfg);
            startIf.load          = uses_osc(oscSelectCfg)
                                    && (primaryOscModeCfg != POSC_EC);
            pwrIf.load            = 1'b1;
            if (powerupTimerEn) begin
              pwrIf.count = CNT_W'(PWRUP_DELAY_CYCLES);
            end else if (uses_osc(oscSelectCfg) && isCrystal) begin
              pwrIf.count = CNT_W'(FSCM_DELAY_CYCLES);
            end else begin
              pwrIf.count = CNT_W'(1);
            end
            next_state = BORS_WAIT;
          end
        end
        BORS_WAIT: begin
          next_oscStartupRun = needStart && !startIf.expired;
          if (clockReady) begin
            next_sysClockEn = 1'b1;
          end
          if (clockReady && pwrIf.expired) begin
            next_internalReset = 1'b0;
            next_state         = BORS_DONE;
          end
        end
        BORS_DONE: begin
          next_state = BORS_RUN;
        end
        default: begin
          next_state = BORS_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state            <= BORS_RUN;
      pulseCnt         <= '0;
      needStart        <= 1'b0;
      needPll          <= 1'b0;
      deviceResetPulse <= 1'b0;
      internalReset    <= 1'b0;
      sysClockEn       <= 1'b1;
      clockSource      <= OSC_SEL_RST;
      oscStartupRun    <= 1'b0;
      supplyDropFlag   <= 1'b0;
    end else begin
      state            <= next_state;
      pulseCnt         <= next_pulseCnt;
      needStart        <= next_needStart;
      needPll          <= next_needPll;
      deviceResetPulse <= next_deviceResetPulse;
      internalReset    <= next_internalReset;
      sysClockEn       <= next_sysClockEn;
      clockSource      <= next_clockSource;
      oscStartupRun    <= next_oscStartupRun;
      supplyDropFlag   <= next_supplyDropFlag;
    end
  end

  // checks
  a_drop_pulses: assert property (@(posedge clk) disable iff (rst)
    supplyLow |=> deviceResetPulse && internalReset)
    else $error("supply drop gave no reset pulse");
  a_drop_sets_flag: assert property (@(posedge clk) disable iff (rst)
    supplyLow |=> supplyDropFlag)
    else $error("supply drop flag not set");
  a_flag_holds: assert property (@(posedge clk) disable iff (rst)
    supplyDropFlag && !(flagWrite && !flagWriteData) |=> supplyDropFlag)
    else $error("flag cleared without software write");
  a_clear_works: assert property (@(posedge clk) disable iff (rst)
    flagWrite && !flagWriteData && !supplyLow |=> !supplyDropFlag)
    else $error("software clear ignored");
  a_start_gate: assert property (@(posedge clk) disable iff (rst)
    state == BORS_WAIT && needStart && !startIf.expired |=> !sysClockEn)
    else $error("clock ran before start-up timer");
  a_pll_gate: assert property (@(posedge clk) disable iff (rst)
    state == BORS_WAIT && needPll && !pllLock && !supplyLow |=> !sysClockEn)
    else $error("clock ran before pll lock");
  a_pwr_hold: assert property (@(posedge clk) disable iff (rst)
    state == BORS_WAIT && !pwrIf.expired |=> internalReset)
    else $error("reset released before power-up delay");
  a_src_select: assert property (@(posedge clk) disable iff (rst)
    state == BORS_PULSE && pulseCnt == 3'(RESET_PULSE_CYCLES - 1) && !supplyLow
    |=> clockSource == $past(oscSelectCfg))
    else $error("clock source not taken from configuration");
  a_sleep_detect: assert property (@(posedge clk) disable iff (rst)
    (sleepMode || idleMode) && supplyLow |=> state == BORS_PULSE)
    else $error("drop missed in low power mode");
  a_pulse_len: assert property (@(posedge clk) disable iff (rst)
    $rose(deviceResetPulse) |-> deviceResetPulse[*4])
    else $error("reset pulse too short");
  a_release_clk: assert property (@(posedge clk) disable iff (rst)
    $fell(internalReset) |-> sysClockEn)
    else $error("reset released before clock ready");
  a_fsafe_load: assert property (@(posedge clk) disable iff (rst)
    state == BORS_PULSE && pulseCnt == 3'(RESET_PULSE_CYCLES - 1) && !supplyLow
    && !powerupTimerEn && uses_osc(oscSelectCfg) && isCrystal
    |-> pwrIf.load && pwrIf.count == CNT_W'(FSCM_DELAY_CYCLES))
    else $error("fail-safe delay not applied");

  c_drop: cover property (@(posedge clk) supplyLow ##1 deviceResetPulse);
  c_release: cover property (@(posedge clk) state == BORS_WAIT ##1 state == BORS_DONE);
  c_pll_wait: cover property (@(posedge clk) state == BORS_WAIT && needPll && !pllLock);
  c_sleep_drop: cover property (@(posedge clk) sleepMode && supplyLow);
  c_fsafe: cover property (@(posedge clk) state == BORS_WAIT && !powerupTimerEn && isCrystal);
endmodule

// ===== src/bors_pkg.sv
package bors_pkg;
  // clock rate and timing
  localparam int unsigned CLK_HZ             = 40000000;
  localparam int unsigned CLK_PERIOD_NS      = 25;
  localparam int unsigned RESET_PULSE_CYCLES = 4;
  localparam int unsigned STARTUP_TMR_CYCLES = 1024;
  // power-up delay in microseconds, applied when powerupTimerEn is set
  localparam int unsigned PWRUP_DELAY_US     = 64;
  localparam int unsigned PWRUP_DELAY_CYCLES =
    (PWRUP_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FSCM_DELAY_US      = 50;
  localparam int unsigned FSCM_DELAY_CYCLES  =
    (FSCM_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W              = 16;
  // clock source selections
  localparam logic [2:0] OSC_FRC     = 3'h0;
  localparam logic [2:0] OSC_FRC_PLL = 3'h1;
  localparam logic [2:0] OSC_PRI     = 3'h2;
  localparam logic [2:0] OSC_PRI_PLL = 3'h3;
  localparam logic [2:0] OSC_SEL_RST = 3'h0;
  // primary oscillator modes
  localparam logic [1:0] POSC_EC     = 2'h0;
  localparam logic [1:0] POSC_XT     = 2'h1;
  localparam logic [1:0] POSC_HS     = 2'h2;
  localparam logic [1:0] POSC_OFF    = 2'h3;
  // reset control register field
  localparam int unsigned RSTCTL_DROP_FLAG_BIT = 1;

  typedef enum logic [2:0] {
    BORS_RUN    = 3'h0,
    BORS_PULSE  = 3'h1,
    BORS_WAIT   = 3'h3,
    BORS_DONE   = 3'h2
  } bors_state_t;
endpackage

// ===== src/bors_if.sv
interface bors_if;
  import bors_pkg::*;
  logic             load;
  logic [CNT_W-1:0] count;
  logic             expired;
  modport ctl (output load, output count, input expired);
  modport tmr (input load, input count, output expired);
endinterface

// ===== src/bors_timer.sv
module bors_timer
  import bors_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // load and expiry
  bors_if.tmr       tif
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             next_expired;

  always_comb begin
    next_cnt     = cnt;
    next_expired = tif.expired;
    if (tif.load) begin
      next_cnt     = tif.count;
      next_expired = 1'b0;
    end else if (cnt != '0) begin
      next_cnt     = cnt - CNT_W'(1);
      next_expired = (cnt == CNT_W'(1));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt         <= '0;
      tif.expired <= 1'b1;
    end else begin
      cnt         <= next_cnt;
      tif.expired <= next_expired;
    end
  end
endmodule

// ===== verif/bors_supply_model.sv
module bors_supply_model #(
  parameter int LOCK_CYCLES = 300
) (
  // clock
  input  wire logic clk,
  // bench request and analog outputs
  input  wire logic dropReq,
  output logic      supplyLow,
  output logic      pllLock
);
  timeunit 1ns;
  timeprecision 1ps;
  int lockCnt = 0;
  initial pllLock = 1'b0;
  assign supplyLow = dropReq;
  // lock lost on a drop, regained after a fixed settling time
  always @(posedge clk) begin
    if (dropReq) begin
      lockCnt <= 0;
      pllLock <= 1'b0;
    end else if (lockCnt < LOCK_CYCLES) begin
      lockCnt <= lockCnt + 1;
    end else begin
      pllLock <= 1'b1;
    end
  end
endmodule

// ===== verif/brownout_reset_sequencer_bench.sv
module brownout_reset_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import bors_pkg::*;
  typedef struct {int pulse; int clkAt; int rstAt; logic [2:0] src; logic stRun;} bors_exp_t;
  localparam int LOCK = 300;
  localparam int TOL  = 0;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       dropReq = 1'b0;
  logic       supplyLow, pllLock, deviceResetPulse, internalReset;
  logic       sysClockEn, oscStartupRun, supplyDropFlag;
  logic [2:0] oscSelectCfg = 3'h0;
  logic [2:0] clockSource;
  logic [1:0] primaryOscModeCfg = 2'h0;
  logic       powerupTimerEn = 1'b0;
  logic       sleepMode = 1'b0;
  logic       idleMode = 1'b0;
  logic       flagWrite = 1'b0;
  logic       flagWriteData = 1'b0;
  int         nMismatch = 0;
  int         numChecks = 0;
  int         cyc = 0;
  int         nDone = 0;
  bors_exp_t  expQ[$];

  bors_supply_model #(.LOCK_CYCLES(LOCK)) model (.clk, .dropReq, .supplyLow, .pllLock);
  bors_sequencer dut (.clk, .rst, .supplyLow, .pllLock, .oscSelectCfg, .primaryOscModeCfg,
    .powerupTimerEn, .sleepMode, .idleMode, .flagWrite, .flagWriteData, .deviceResetPulse,
    .internalReset, .sysClockEn, .clockSource, .oscStartupRun, .supplyDropFlag);

  initial forever #12.5 clk = ~clk;

  task automatic conclude();
    $display("checks %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chkEq(input logic [31:0] got, input logic [31:0] exp, input string what);
    numChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic chkNear(input int got, input int exp, input string what);
    numChecks++;
    if (got < exp - TOL || got > exp + TOL) begin
      nMismatch++;
      $display("[FAIL] %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      nMismatch++;
      conclude();
    end
  end

  // driver: one supply drop per configuration, expectations queued
  initial begin
    int n, stw, pwr, pll, p;
    bors_exp_t e;
    n = $urandom(32'hA76700E3);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chkEq({sysClockEn, deviceResetPulse, internalReset, supplyDropFlag, clockSource},
      7'h40, "reset state");
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      flagWrite <= 1'b1;
      flagWriteData <= 1'b1;
      @(posedge clk);
      flagWriteData <= 1'b0;
      #1 chkEq(supplyDropFlag, i > 0, "flag kept on write of one");
      @(posedge clk);
      flagWrite <= 1'b0;
      oscSelectCfg <= 3'(i % 4);
      primaryOscModeCfg <= 2'(i / 4);
      powerupTimerEn <= (i < 6);
      sleepMode <= 1'($urandom % 2);
      idleMode <= 1'($urandom % 2);
      #1 chkEq(supplyDropFlag, 1'b0, "flag cleared");
      n = 1 + $urandom % 3;
      stw = (i % 4 >= 2 && i / 4 != 0) ? STARTUP_TMR_CYCLES : 0;
      pwr = (i < 6) ? PWRUP_DELAY_CYCLES : (stw > 0) ? FSCM_DELAY_CYCLES : 1;
      pll = (i % 2 == 1) ? LOCK + n : 0;
      p = n + 3;
      e.pulse = p;
      e.clkAt = ((p + stw > pll) ? p + stw : pll) + 1;
      // release one edge after both clock ready and power-up delay done
      e.rstAt = ((e.clkAt - 1 > p + pwr) ? e.clkAt - 1 : p + pwr) + 1;
      e.src = 3'(i % 4);
      e.stRun = stw > 0;
      expQ.push_back(e);
      @(posedge clk);
      dropReq <= 1'b1;
      flagWrite <= 1'b1;
      @(posedge clk);
      flagWrite <= 1'b0;
      repeat (n - 1) @(posedge clk);
      dropReq <= 1'b0;
      while (nDone <= i) @(posedge clk);
    end
    conclude();
  end

  // monitor: measures each reset sequence against the oldest note
  initial begin
    int t, tp, tc;
    logic seenStart;
    bors_exp_t e;
    forever begin
      @(negedge clk);
      if (deviceResetPulse === 1'b1) begin
        e = expQ.pop_front();
        t = 0;
        tp = 0;
        tc = -1;
        seenStart = 1'b0;
        chkEq({internalReset, sysClockEn}, 2'h2, "reset entry");
        while (internalReset === 1'b1 && t < 5000) begin
          if (deviceResetPulse === 1'b1) tp = t + 1;
          if (sysClockEn === 1'b1 && tc < 0) tc = t;
          if (oscStartupRun === 1'b1) seenStart = 1'b1;
          @(negedge clk);
          t++;
        end
        // clock and reset may open at the same edge
        if (sysClockEn === 1'b1 && tc < 0) tc = t;
        chkEq(tp, e.pulse, "pulse width");
        chkNear(tc, e.clkAt, "clock gate");
        chkNear(t, e.rstAt, "reset release");
        chkEq(clockSource, e.src, "clock source");
        chkEq(seenStart, e.stRun, "start-up timer run");
        chkEq(supplyDropFlag, 1'b1, "status flag");
        nDone++;
      end
    end
  end
endmodule
